/* File: rtl/efl_top.sv */
// Engine driver fault logic: injector, relay and ignition pre-driver control
// with fault latching, plus an AHB-Lite register slave.
// Assumes comparator and control pins are asynchronous to clk; one bus slave.
// Analog current limiting and clamps sit outside this logic.
`timescale 1ns/10ps
`include "efl_regs.svh"
module efl_top #(
  parameter int FILT_W = `EFL_FILT_W
) (
  input  wire logic        clk,                      // 20 MHz system clock.
  input  wire logic        nrst,                     // Synchronous reset, active low.
  input  wire logic        injector_control_input,   // Injector on request pin.
  input  wire logic        relay_control_input,      // Relay on request pin.
  input  wire logic        ignition_control_input,   // Ignition on request pin.
  input  wire logic        supplyOvervoltage,        // Main supply above threshold.
  input  wire logic        injShortCmp,              // Injector drain above short level.
  input  wire logic        injOpenCmp,               // Injector drain below open level.
  input  wire logic        injOverTemp,              // Injector temperature limit.
  input  wire logic        relShortCmp,              // Relay drain above short level.
  input  wire logic        relOpenCmp,               // Relay drain below open level.
  input  wire logic        relOverTemp,              // Relay temperature limit.
  input  wire logic        ignFeedbackOverCmp,       // Feedback above overcurrent level.
  input  wire logic        ignFeedbackOpenCmp,       // Feedback below open level.
  output logic             injector_output,          // High: injector switched on.
  output logic             relay_output,             // High: relay switched on.
  output logic             ignition_high_side_output,// High: pull to pre-driver supply.
  output logic             ignition_low_side_output, // High: pull to ground.
  output logic             injector_fault_flag,      // Injector fault, active high.
  output logic             relay_fault_flag,         // Relay fault, active high.
  output logic             ignition_fault_flag,      // Ignition fault, active high.
  input  wire logic        hsel,                     // AHB slave select.
  input  wire logic [31:0] haddr,                    // AHB address.
  input  wire logic [1:0]  htrans,                   // AHB transfer type.
  input  wire logic        hwrite,                   // AHB write strobe.
  input  wire logic [2:0]  hsize,                    // AHB size, word only.
  input  wire logic [31:0] hwdata,                   // AHB write data.
  input  wire logic        hready,                   // AHB bus ready.
  output logic             hreadyout,                // Low in reset, ready from the first edge after.
  output logic             hresp,                    // Always OKAY.
  output logic [31:0]      hrdata                    // Read data.
);

  // Refuse filter widths the filter register cannot carry.
  // Wider filters would only cost counter area, but the register is capped.
  if (FILT_W < 1 || FILT_W > 16) begin : gBadFilt
    $error("FILT_W must lie between 1 and 16");
  end

  // Pin vector order, lowest bit first: the three control pins, overvoltage,
  // then the injector, relay and ignition comparators in their groups.
  // Adding a pin means widening the count and extending the taps below.
  localparam int NPIN = `EFL_NPIN;

  // Synchroniser stages and the named taps that the logic reads.
  logic [NPIN-1:0]   pinRaw;
  logic [NPIN-1:0]   sync1_q;
  logic [NPIN-1:0]   sync2_q;
  logic              injCtrl;
  logic              relCtrl;
  logic              ignCtrl;
  logic              overVolt;
  logic              ignOver;
  logic              ignOpen;

  // Pin inputs gathered into one vector for the synchroniser.
  assign pinRaw = {ignFeedbackOpenCmp, ignFeedbackOverCmp, relOverTemp, relOpenCmp,
                   relShortCmp, injOverTemp, injOpenCmp, injShortCmp,
                   supplyOvervoltage, ignition_control_input, relay_control_input,
                   injector_control_input};

  // two-stage synchroniser
  // The first stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
    end
  end

  // Named taps of the second stage; the injector and relay comparator taps feed
  // the channels directly further down.
  assign injCtrl  = sync2_q[0];
  assign relCtrl  = sync2_q[1];
  assign ignCtrl  = sync2_q[2];
  assign overVolt = sync2_q[3];
  assign ignOver  = sync2_q[10];
  assign ignOpen  = sync2_q[11];

  // Software registers. The enables park a driver without touching its pin;
  // they do not clear a latched fault.
  logic [`EFL_CTRL_W-1:0] ctrl_q;
  logic [`EFL_CTRL_W-1:0] ctrl_d;
  logic [FILT_W-1:0]      filt_q;
  logic [FILT_W-1:0]      filt_d;

  // Injector and relay share one channel design.
  // Both see the same filter length, so one write tunes both shorts.
  efl_chan_if #(.FILT_W(FILT_W)) injIf ();
  efl_chan_if #(.FILT_W(FILT_W)) relIf ();

  // Injector channel inputs, all synchronised already.
  assign injIf.ctrlIn   = injCtrl;
  assign injIf.overVolt = overVolt;
  assign injIf.shortCmp = sync2_q[4];
  assign injIf.openCmp  = sync2_q[5];
  assign injIf.overTemp = sync2_q[6];
  assign injIf.enable   = ctrl_q[`EFL_CTRL_INJ_EN];
  assign injIf.filtLen  = filt_q;

  assign relIf.ctrlIn   = relCtrl;
  assign relIf.overVolt = overVolt;
  assign relIf.shortCmp = sync2_q[7];
  assign relIf.openCmp  = sync2_q[8];
  assign relIf.overTemp = sync2_q[9];
  assign relIf.enable   = ctrl_q[`EFL_CTRL_REL_EN];
  assign relIf.filtLen  = filt_q;

  // Injector channel.
  efl_lsd_chan #(.FILT_W(FILT_W)) uInj (
    .clk  (clk),
    .nrst (nrst),
    .ch   (injIf.chan)
  );

  efl_lsd_chan #(.FILT_W(FILT_W)) uRel (
    .clk  (clk),
    .nrst (nrst),
    .ch   (relIf.chan)
  );

  // Ignition pre-driver state. Unlike the low-side channels there is no
  // filter here: the feedback comparator already sees a divided voltage.
  logic ignPrev_q;
  logic ignLatch_q;
  logic ignLatch_d;
  logic ignition_fault_flag_q;
  logic ignition_fault_flag_d;
  logic ignHigh_q;
  logic ignLow_q;
  logic ignOn_d;
  logic ignRise;
  logic ignOverHit;
  logic ignOpenHit;

  // Edge detector: a low sample followed by a high one, after synchronising.
  assign ignRise    = ignCtrl & ~ignPrev_q;
  // combined overcurrent fault
  // The feedback comparator already sits behind the external divider scaling.
  assign ignOverHit = ignOver & ignHigh_q;
  assign ignOpenHit = ignOpen & ~ignHigh_q;
  assign ignLatch_d = overVolt | ignOverHit | (ignLatch_q & ~(ignRise & ~overVolt));
  // no overtemperature input
  // The external transistor's temperature is unknown here, so nothing gates on it.
  assign ignOn_d    = ignCtrl & ctrl_q[`EFL_CTRL_IGN_EN] & ~ignLatch_d;
  assign ignition_fault_flag_d   = ignOverHit | ignOpenHit | overVolt | (ignition_fault_flag_q & ~ignRise);

  // outputs off in reset
  // Both stages idle in reset so no cross-conduction happens at power up.
  // both sides off
  // A latched fault idles both sides too; the low side only pulls the gate
  // down while the stage is healthy and not asked to conduct.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ignPrev_q  <= 1'b0;
      ignLatch_q <= 1'b0;
      ignition_fault_flag_q   <= 1'b0;
      ignHigh_q  <= 1'b0;
      ignLow_q   <= 1'b0;
    end else begin
      ignPrev_q  <= ignCtrl;
      ignLatch_q <= ignLatch_d;
      ignition_fault_flag_q   <= ignition_fault_flag_d;
      ignHigh_q  <= ignOn_d;
      ignLow_q   <= ~ignOn_d & ~ignLatch_d;
    end
  end

  // Driver outputs come straight from the channel and ignition flip-flops.
  // Software sees the same flops through the status register, except the ignition low side.
  assign injector_output           = injIf.drvOn;
  assign relay_output              = relIf.drvOn;
  assign ignition_high_side_output = ignHigh_q;
  assign ignition_low_side_output  = ignLow_q;
  assign injector_fault_flag       = injIf.fault;
  assign relay_fault_flag          = relIf.fault;
  assign ignition_fault_flag       = ignition_fault_flag_q;

  // AHB-Lite slave: zero wait states, every transfer answered OKAY.
  // A master must still wait for hreadyout after reset, since it stays low
  // until the first edge with reset released.
  logic                        addrPhase;
  logic                        wrPend_q;
  efl_pkg::efl_reg_sel_t       wrSel_q;
  efl_pkg::efl_reg_sel_t       addrSel;
  efl_pkg::efl_word_t          rdData_q;
  efl_pkg::efl_word_t          rdMux;
  logic [`EFL_ST_W-1:0]        status;
  logic                        hreadyout_q;
  logic                        hresp_q;
  logic [`EFL_ADDR_W-1:0]      offset;

  // A transfer is taken only once the previous one has completed.
  assign addrPhase = hsel & htrans[1] & hready;
  assign offset    = haddr[`EFL_ADDR_W-1:0];
  // Only the low offset bits decode; higher address bits alias the map.
  assign addrSel   = (offset == `EFL_OFF_CTRL) ? efl_pkg::SEL_CTRL :
                     (offset == `EFL_OFF_FILT) ? efl_pkg::SEL_FILT :
                     (offset == `EFL_OFF_STAT) ? efl_pkg::SEL_STAT :
                                                 efl_pkg::SEL_NONE;

  // Write data arrives in the data phase; the _d values let a read that
  // directly follows a write see the new contents.
  // Only the low bits of hwdata are kept; the rest is ignored.
  assign ctrl_d = (wrPend_q && wrSel_q == efl_pkg::SEL_CTRL) ?
                  hwdata[`EFL_CTRL_W-1:0] : ctrl_q;
  assign filt_d = (wrPend_q && wrSel_q == efl_pkg::SEL_FILT) ?
                  hwdata[FILT_W-1:0] : filt_q;

  // Live state seen by software. Pins are shown after synchronisation, so
  // a read lags the pins by two cycles.
  assign status = {ignCtrl, relCtrl, injCtrl, overVolt, ignLatch_q,
                   relIf.latchedOff, injIf.latchedOff, ignition_fault_flag_q, relIf.fault,
                   injIf.fault, ignHigh_q, relIf.drvOn, injIf.drvOn};

  // Read selection; unmapped offsets read as zero.
  // Reads have no side effect, so software may poll the status freely.
  assign rdMux = (addrSel == efl_pkg::SEL_CTRL) ? {{(32-`EFL_CTRL_W){1'b0}}, ctrl_d} :
                 (addrSel == efl_pkg::SEL_FILT) ? {{(32-FILT_W){1'b0}}, filt_d} :
                 (addrSel == efl_pkg::SEL_STAT) ? {{(32-`EFL_ST_W){1'b0}}, status} :
                                                  32'h0000_0000;

  // Bus registers; writes to status or unmapped offsets are dropped.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPend_q    <= 1'b0;
      wrSel_q     <= efl_pkg::SEL_NONE;
      rdData_q    <= 32'h0000_0000;
      ctrl_q      <= `EFL_CTRL_RST;
      filt_q      <= FILT_W'(`EFL_FILT_RST);
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end else begin
      wrPend_q    <= addrPhase & hwrite;
      wrSel_q     <= addrSel;
      rdData_q    <= (addrPhase & ~hwrite) ? rdMux : 32'h0000_0000;
      ctrl_q      <= ctrl_d;
      filt_q      <= filt_d;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  // Bus outputs; the response stays OKAY but still leaves a flop.
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = rdData_q;

endmodule

/* File: rtl/efl_regs.svh */
// Register offsets, field positions, reset values and filter defaults of the
// engine driver fault logic. Definitions only; included by the top level and the bench.
`ifndef EFL_REGS_SVH
`define EFL_REGS_SVH

// Byte offsets of the software registers on the AHB-Lite bus.
`define EFL_ADDR_W          8
`define EFL_OFF_CTRL        8'h00
`define EFL_OFF_FILT        8'h04
`define EFL_OFF_STAT        8'h08

// Control register: per-driver software enables.
`define EFL_CTRL_INJ_EN     0
`define EFL_CTRL_REL_EN     1
`define EFL_CTRL_IGN_EN     2
`define EFL_CTRL_W          3
`define EFL_CTRL_RST        3'h7

// Short-to-battery filter length in clock cycles; zero acts as one.
`define EFL_FILT_W          8
`define EFL_FILT_RST        8'h10

// Status register fields.
`define EFL_ST_INJ_OUT      0
`define EFL_ST_REL_OUT      1
`define EFL_ST_IGN_HIGH     2
`define EFL_ST_INJ_FLT      3
`define EFL_ST_REL_FLT      4
`define EFL_ST_IGN_FLT      5
`define EFL_ST_INJ_LATCH    6
`define EFL_ST_REL_LATCH    7
`define EFL_ST_IGN_LATCH    8
`define EFL_ST_OVERVOLT     9
`define EFL_ST_INJ_CTRL     10
`define EFL_ST_REL_CTRL     11
`define EFL_ST_IGN_CTRL     12
`define EFL_ST_W            13

// Number of asynchronous pin inputs passed through the synchroniser.
`define EFL_NPIN            12

`endif

/* File: rtl/efl_pkg.sv */
// Types shared by the engine driver fault logic.
// Assumes the register constants come from efl_regs.svh.
package efl_pkg;

  // One-hot register select produced by the bus address decode.
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_CTRL = 4'b0010,
    SEL_FILT = 4'b0100,
    SEL_STAT = 4'b1000
  } efl_reg_sel_t;

  typedef logic [31:0] efl_word_t;

endpackage

/* File: rtl/efl_chan_if.sv */
// Signals between the top level and one low-side driver channel.
// Assumes every input is already synchronised to clk.
`timescale 1ns/10ps
interface efl_chan_if #(
  parameter int FILT_W = 8
);
  logic              ctrlIn;     // Synchronised control input level.
  logic              overVolt;   // Supply overvoltage indication.
  logic              shortCmp;   // Drain above short threshold.
  logic              openCmp;    // Drain below open-load threshold.
  logic              overTemp;   // Junction temperature limit indication.
  logic              enable;     // Software enable of this driver.
  logic [FILT_W-1:0] filtLen;    // Short filter length in cycles.
  logic              drvOn;      // Driver switched on, pulls to ground.
  logic              fault;      // Latched fault flag.
  logic              latchedOff; // Output held off until a toggle.

  modport chan (
    input  ctrlIn, overVolt, shortCmp, openCmp, overTemp, enable, filtLen,
    output drvOn, fault, latchedOff
  );
  modport ctl (
    output ctrlIn, overVolt, shortCmp, openCmp, overTemp, enable, filtLen,
    input  drvOn, fault, latchedOff
  );
endinterface

/* File: rtl/efl_lsd_chan.sv */
// One protected low-side driver channel, used for the injector and the relay.
// Assumes synchronised inputs arriving through efl_chan_if on clk.
`timescale 1ns/10ps
module efl_lsd_chan #(
  parameter int FILT_W = 8
) (
  input wire logic clk,  // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  efl_chan_if.chan ch    // Channel signals.
);

  logic              ctrlPrev_q;
  logic [FILT_W-1:0] shortCnt_q;
  logic [FILT_W-1:0] shortCnt_d;
  logic              latch_q;
  logic              latch_d;
  logic              fault_q;
  logic              fault_d;
  logic              drvOn_q;
  logic              drvOn_d;
  logic [FILT_W-1:0] filtTarget;
  logic              rise;
  logic              shortActive;
  logic              shortHit;
  logic              latchSet;
  logic              faultSet;

  // A rising edge can only follow a low sample, so it proves the toggle.
  assign rise        = ch.ctrlIn & ~ctrlPrev_q;
  assign filtTarget  = (ch.filtLen == '0) ? FILT_W'(1) : ch.filtLen;
  assign shortActive = ch.shortCmp & drvOn_q;
  assign shortHit    = shortActive & (shortCnt_q >= filtTarget - FILT_W'(1));
  assign shortCnt_d  = (shortActive & ~shortHit) ? shortCnt_q + FILT_W'(1) : '0;

  assign latchSet = shortHit | ch.overVolt;
  assign latch_d  = latchSet | (latch_q & ~(rise & ~ch.overVolt));

  assign drvOn_d  = ch.ctrlIn & ch.enable & ~latch_d & ~ch.overTemp;

  assign faultSet = shortHit | ch.overTemp | ch.overVolt | (ch.openCmp & ~drvOn_q);
  assign fault_d  = faultSet | (fault_q & ~rise);

  // Channel state; reset leaves the driver off with no fault recorded.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrlPrev_q <= 1'b0;
      shortCnt_q <= '0;
      latch_q    <= 1'b0;
      fault_q    <= 1'b0;
      drvOn_q    <= 1'b0;
    end else begin
      ctrlPrev_q <= ch.ctrlIn;
      shortCnt_q <= shortCnt_d;
      latch_q    <= latch_d;
      fault_q    <= fault_d;
      drvOn_q    <= drvOn_d;
    end
  end

  assign ch.drvOn      = drvOn_q;
  assign ch.fault      = fault_q;
  assign ch.latchedOff = latch_q;

endmodule

/* File: dv/efl_mcu_model.sv */
// Controller model: drives the three control pins of the driver logic.
// Assumes the bench asks for levels and for a low-then-high clear toggle.
`timescale 1ns/10ps
module efl_mcu_model (
  input  wire logic       clk,      // System clock.
  input  wire logic       nrst,     // Synchronous reset, active low.
  input  wire logic [2:0] wantOn,   // Requested pin levels: ign, rel, inj.
  input  wire logic [2:0] clearReq, // One-cycle request to toggle pins.
  output logic      [2:0] ctrlPins  // Control pins towards the device.
);
  logic [2:0] mask_q;
  logic [2:0] cnt_q;

  // clear by toggle
  // Pins go low for five cycles, longer than the two the synchroniser needs.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_q <= 3'h0;
      cnt_q  <= 3'h0;
    end else if (clearReq != 3'h0) begin
      mask_q <= clearReq;
      cnt_q  <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end else begin
      mask_q <= 3'h0;
    end
  end

  // Levels change only after a clock edge, never mid-cycle.
  assign ctrlPins = wantOn & ~mask_q;
endmodule

/* File: dv/efl_top_props.sv */
// Concurrent checks on the pins of the engine driver fault logic.
// Assumes it is bound to efl_top; pins settle three edges after a change.
`timescale 1ns/10ps
module efl_top_props (
  input wire logic clk,                       // System clock.
  input wire logic nrst,                      // Synchronous reset, active low.
  input wire logic injector_control_input,    // Injector request pin.
  input wire logic relay_control_input,       // Relay request pin.
  input wire logic ignition_control_input,    // Ignition request pin.
  input wire logic supplyOvervoltage,         // Supply overvoltage pin.
  input wire logic injOverTemp,               // Injector temperature limit.
  input wire logic relOverTemp,               // Relay temperature limit.
  input wire logic injector_output,           // Injector driver on.
  input wire logic relay_output,              // Relay driver on.
  input wire logic ignition_high_side_output, // Ignition high side on.
  input wire logic ignition_low_side_output,  // Ignition low side on.
  input wire logic injector_fault_flag,       // Injector flag.
  input wire logic relay_fault_flag,          // Relay flag.
  input wire logic ignition_fault_flag        // Ignition flag.
);
  logic allOff;

  // Every driver off; the ignition low side is judged separately.
  assign allOff = !injector_output && !relay_output && !ignition_high_side_output;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_RESET_OFF: assert property ($rose(nrst) |-> allOff[*2])
    else $error("driver on right after reset");
  AST_INJ_FOLLOW: assert property (injector_output |-> $past(injector_control_input, 3))
    else $error("injector on without its request");
  AST_REL_FOLLOW: assert property (relay_output |-> $past(relay_control_input, 3))
    else $error("relay on without its request");
  AST_IGN_FOLLOW: assert property (
    ignition_high_side_output |-> $past(ignition_control_input, 3))
    else $error("ignition high side on without its request");
  AST_IGN_EXCL: assert property (
    ignition_high_side_output |-> !ignition_low_side_output)
    else $error("both ignition sides on");
  AST_OV_OFF: assert property ($rose(supplyOvervoltage) |-> ##4 allOff)
    else $error("driver still on during overvoltage");
  AST_INJ_TEMP: assert property (injOverTemp[*4] |-> !injector_output)
    else $error("injector on while too hot");
  AST_REL_TEMP: assert property (
    relOverTemp[*5] |-> !relay_output && relay_fault_flag)
    else $error("relay on or flag low while too hot");
  AST_INJ_FLAG_HOLD: assert property ($fell(injector_fault_flag) |->
    $past(injector_control_input, 3) && !($past(injector_control_input, 4)
    && $past(injector_control_input, 5) && $past(injector_control_input, 6)))
    else $error("injector flag cleared without a toggle");
  AST_IGN_FLAG_HOLD: assert property ($fell(ignition_fault_flag) |->
    $past(ignition_control_input, 3) && !($past(ignition_control_input, 4)
    && $past(ignition_control_input, 5) && $past(ignition_control_input, 6)))
    else $error("ignition flag cleared without a toggle");

  // Main scenarios reached.
  cover property ($fell(injector_output) && injector_control_input);
  cover property ($rose(relay_fault_flag));
  cover property ($rose(ignition_fault_flag));
endmodule

bind efl_top efl_top_props efl_top_props_i (
  .clk, .nrst, .injector_control_input, .relay_control_input, .ignition_control_input,
  .supplyOvervoltage, .injOverTemp, .relOverTemp, .injector_output, .relay_output,
  .ignition_high_side_output, .ignition_low_side_output, .injector_fault_flag,
  .relay_fault_flag, .ignition_fault_flag
);

/* File: dv/tb_top.sv */
// Self-checking bench for the engine driver fault logic.
// Assumes the controller model drives the pins and the bench is the bus master.
`timescale 1ns/10ps
`include "efl_regs.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  wantOn = 3'h0;
  logic [2:0]  clearReq = 3'h0;
  logic [2:0]  ctrlPins;
  logic [1:0]  shortCmp = 2'h0;
  logic [1:0]  openCmp = 2'h0;
  logic [1:0]  overTemp = 2'h0;
  logic        ov = 1'b0;
  logic        ignOver = 1'b0;
  logic        ignOpen = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        hreadyout;
  logic        hresp;
  wire  [3:0]  drv;
  wire  [2:0]  flg;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #25 clk = ~clk;

  efl_top efl_top_i (
    .clk(clk), .nrst(nrst), .injector_control_input(ctrlPins[0]),
    .relay_control_input(ctrlPins[1]), .ignition_control_input(ctrlPins[2]),
    .supplyOvervoltage(ov), .injShortCmp(shortCmp[0]), .injOpenCmp(openCmp[0]),
    .injOverTemp(overTemp[0]), .relShortCmp(shortCmp[1]), .relOpenCmp(openCmp[1]),
    .relOverTemp(overTemp[1]), .ignFeedbackOverCmp(ignOver), .ignFeedbackOpenCmp(ignOpen),
    .injector_output(drv[0]), .relay_output(drv[1]), .ignition_high_side_output(drv[2]),
    .ignition_low_side_output(drv[3]), .injector_fault_flag(flg[0]),
    .relay_fault_flag(flg[1]), .ignition_fault_flag(flg[2]), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  efl_mcu_model efl_mcu_model_i (
    .clk(clk), .nrst(nrst), .wantOn(wantOn), .clearReq(clearReq), .ctrlPins(ctrlPins));

  task automatic ck(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Outputs are looked at on the falling edge, well clear of the updates.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One single AHB-Lite transfer; the address phase holds until ready.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    ck("register read", exp, q);
    ck("bus response", 32'h0, {31'h0, hresp});
  endtask

  task automatic clr(input logic [2:0] m);
    @(posedge clk);
    clearReq <= m;
    @(posedge clk);
    clearReq <= 3'h0;
    cyc(10);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude;
    end
  end

  initial begin
    cyc(8);
    ck("drivers in reset", 32'h0, {28'h0, drv});
    @(posedge clk) nrst <= 1'b1;
    rd(`EFL_OFF_CTRL, {29'h0, `EFL_CTRL_RST});
    rd(`EFL_OFF_FILT, {24'h0, `EFL_FILT_RST});
    rd(8'h40, 32'h0);
    bus(1'b1, `EFL_OFF_FILT, 32'h2);
    rd(`EFL_OFF_FILT, 32'h2);
    bus(1'b1, `EFL_OFF_STAT, 32'hFFFFFFFF);
    rd(`EFL_OFF_STAT, 32'h0);
    @(posedge clk) wantOn <= 3'h7;
    cyc(4);
    ck("all on", 32'h7, {28'h0, drv});
    @(posedge clk) wantOn <= 3'h0;
    cyc(4);
    ck("all off", 32'h8, {28'h0, drv});
    @(posedge clk) wantOn <= 3'h7;
    cyc(4);
    // Injector then relay: filtered short, then temperature limit.
    for (int ch = 0; ch < 2; ch++) begin
      @(posedge clk) shortCmp[ch] <= 1'b1;
      cyc(3);
      ck("on inside filter", 32'h1, {31'h0, drv[ch]});
      cyc(6);
      ck("off after short", 32'h0, {31'h0, drv[ch]});
      ck("short flag", 32'h1, {31'h0, flg[ch]});
      @(posedge clk) shortCmp[ch] <= 1'b0;
      cyc(4);
      ck("short latched", 32'h0, {31'h0, drv[ch]});
      clr(3'h1 << ch);
      ck("on after toggle", 32'h1, {31'h0, drv[ch]});
      ck("flag cleared", 32'h0, {31'h0, flg[ch]});
      @(posedge clk) overTemp[ch] <= 1'b1;
      cyc(5);
      ck("off when hot", 32'h0, {31'h0, drv[ch]});
      ck("hot flag", 32'h1, {31'h0, flg[ch]});
      @(posedge clk) overTemp[ch] <= 1'b0;
      cyc(5);
      ck("on when cool", 32'h1, {31'h0, drv[ch]});
      ck("hot flag held", 32'h1, {31'h0, flg[ch]});
      clr(3'h1 << ch);
      ck("hot flag cleared", 32'h0, {31'h0, flg[ch]});
    end
    // Open load counts only while the driver is off.
    @(posedge clk) openCmp <= 2'h3;
    ignOpen <= 1'b1;
    cyc(5);
    ck("open ignored when on", 32'h0, {29'h0, flg});
    @(posedge clk) wantOn <= 3'h0;
    cyc(5);
    ck("open flagged when off", 32'h7, {29'h0, flg});
    @(posedge clk) openCmp <= 2'h0;
    ignOpen <= 1'b0;
    @(posedge clk) wantOn <= 3'h7;
    cyc(6);
    ck("open cleared", 32'h0, {29'h0, flg});
    // Overvoltage latches every driver off until cleared and toggled.
    @(posedge clk) ov <= 1'b1;
    cyc(5);
    ck("off in overvoltage", 32'h0, {28'h0, drv});
    ck("overvoltage flags", 32'h7, {29'h0, flg});
    @(posedge clk) ov <= 1'b0;
    cyc(5);
    ck("held off after", 32'h0, {28'h0, drv});
    rd(`EFL_OFF_STAT, 32'h0000_1DF8);
    clr(3'h7);
    ck("on after toggle", 32'h7, {28'h0, drv});
    ck("flags cleared", 32'h0, {29'h0, flg});
    // Ignition overcurrent is one latched fault.
    @(posedge clk) ignOver <= 1'b1;
    cyc(4);
    ck("ign off on overcurrent", 32'h0, {31'h0, drv[2]});
    ck("ign flag", 32'h1, {31'h0, flg[2]});
    @(posedge clk) ignOver <= 1'b0;
    cyc(4);
    ck("ign flag held", 32'h1, {31'h0, flg[2]});
    clr(3'h4);
    ck("ign on again", 32'h1, {31'h0, drv[2]});
    ck("ign flag cleared", 32'h0, {31'h0, flg[2]});
    // Software enables off park every driver; the ignition low side turns on.
    bus(1'b1, `EFL_OFF_CTRL, 32'h0);
    cyc(2);
    ck("drivers disabled", 32'h8, {28'h0, drv});
    conclude;
  end
endmodule
